// ==== bench/cxu_bus_model.sv ====
/* Bus and interrupt-controller model: ends acknowledge cycles and service.
   Assumes the exception unit's action, ack_req and handshake ports. */
`timescale 1ns/100ps
module cxu_bus_model
  import cxu_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic ack_req,
  input wire cxu_action_t action,
  output logic ack_done,
  output logic service_done
);
  logic [2:0] cnt;
  logic busy;
  logic acked;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      {cnt, busy, acked, ack_done, service_done} <= '0;
    end else begin
      ack_done <= 1'b0;
      service_done <= 1'b0;
      if (action.take) begin
        busy <= 1'b1;
        cnt <= 3'h0;
      end else if (busy && cnt == (slow ? 3'h3 : 3'h0)) begin
        cnt <= 3'h0;
        // The returned byte is not modelled, since the unit must ignore it.
        if (ack_req && !acked) begin
          ack_done <= 1'b1;
          acked <= 1'b1;
        end else if (acked || !(action.kind inside {CXU_EX_NMI, CXU_EX_INT})) begin
          service_done <= 1'b1;
          busy <= 1'b0;
          acked <= 1'b0;
        end
      end else if (busy) begin
        cnt <= cnt + 3'h1;
      end
    end
  end
endmodule

// ==== bench/cxu_exception_unit_properties.sv ====
/* Concurrent checks on the exception unit's ports.
   Assumes one clock domain with an asynchronous active-low reset. */
`timescale 1ns/100ps
module cxu_exception_unit_properties
  import cxu_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic bus_fault_input,
  input wire cxu_cycle_t bus_cycle,
  input wire cxu_decode_t decode,
  input wire logic service_done,
  input wire cxu_action_t action,
  input wire logic [31:0] return_addr,
  input wire logic ack_req,
  input wire logic [31:0] ack_addr,
  input wire logic [4:0] ack_status,
  input wire logic data_ref_block,
  input wire logic mem_ref_stall,
  input wire logic debug_status_update,
  input wire logic stopped_state
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  chk_nmi_vector: assert property (
    action.take && action.kind == CXU_EX_NMI |-> action.vector == 8'h01)
    else $error("nmi vector wrong");
  chk_nmi_ack_addr: assert property (
    ack_req && action.kind == CXU_EX_NMI |-> ack_addr == 32'h0ffff_f00 && ack_status == 5'h04)
    else $error("nmi acknowledge address wrong");
  chk_trap_keep_ie: assert property (
    action.take && action.kind inside {CXU_EX_PRV, CXU_EX_UND, CXU_EX_SVC, CXU_EX_DVZ,
    CXU_EX_FLG, CXU_EX_BPT, CXU_EX_OVF} |-> !action.clear_int_enable)
    else $error("trap disabled interrupts");
  chk_abt_clear_ie: assert property (
    action.take && action.kind inside {CXU_EX_ABT, CXU_EX_DBG} |-> action.clear_int_enable)
    else $error("interrupts left enabled");
  chk_ret_first: assert property (
    action.take && action.kind inside {CXU_EX_ABT, CXU_EX_PRV, CXU_EX_UND, CXU_EX_SVC,
    CXU_EX_DVZ, CXU_EX_FLG, CXU_EX_BPT} |-> action.ret_first_byte)
    else $error("return address not first byte");
  chk_nbe_undef: assert property (
    action.take && action.kind == CXU_EX_NBE |-> action.ret_undefined && return_addr == 32'h0)
    else $error("fault return address defined");
  chk_undef_block: assert property (
    decode.valid && decode.undefined_opcode |-> data_ref_block)
    else $error("data references not blocked");
  chk_stop_hold: assert property (
    stopped_state |=> stopped_state)
    else $error("stopped state left");
  chk_fatal_stop: assert property (
    bus_fault_input && bus_cycle.active && bus_cycle.for_exception |-> ##[1:2] stopped_state)
    else $error("fatal fault did not stop");
  chk_stall_hold: assert property (
    mem_ref_stall && !service_done |=> mem_ref_stall)
    else $error("stall released early");
  chk_dbg_status: assert property (
    debug_status_update |-> action.kind == CXU_EX_DBG)
    else $error("debug status updated without debug trap");
endmodule
bind cxu_exception_unit cxu_exception_unit_properties cxu_exception_unit_properties_i (.*);

// ==== bench/tb_cxu_exception_unit.sv ====
/* Self-checking bench of the exception unit with a bus model.
   Assumes the unit, its package, header and checker compile alongside. */
`timescale 1ns/100ps
`include "cxu_regs.svh"
module tb_cxu_exception_unit
  import cxu_pkg::*;
;
  typedef struct packed {cxu_exc_t k; logic [7:0] v; logic r; logic [31:0] a;} cxu_exp_t;
  logic clk_sys = 1'b0, rst_n = 1'b0, slow = 1'b0, nmi_request_n = 1'b1;
  logic maskable_request_n = 1'b1, user_mode = 1'b0, int_enable = 1'b0;
  logic overflow_enable = 1'b0, status_flag = 1'b0, step_pending = 1'b0;
  logic ack_done, service_done, ack_req, data_ref_block, mem_ref_stall;
  logic debug_status_update, stopped_state;
  wire interruptible_point, debug_request_input_n, debug_condition_hit;
  wire bus_fault_input, page_fault_detect, insn_complete, boundary;
  logic [6:0] evb = 7'h00;
  logic [2:0] setup_word = 3'h0;
  logic [4:0] ack_status;
  logic [31:0] insn_addr = 32'h0, return_addr, ack_addr, lfsr = 32'h0000_7e4e;
  cxu_cycle_t bus_cycle = '0;
  cxu_decode_t decode = '0;
  cxu_action_t action;
  cxu_exp_t q[$];
  cxu_exp_t e;
  int num_errors = 0, comparisons = 0;
  cxu_exc_t kt[15] = '{CXU_EX_PRV, CXU_EX_UND, CXU_EX_UND, CXU_EX_UND, CXU_EX_UND,
    CXU_EX_UND, CXU_EX_UND, CXU_EX_UND, CXU_EX_SVC, CXU_EX_DVZ, CXU_EX_FLG, CXU_EX_BPT,
    CXU_EX_OVF, CXU_EX_NONE, CXU_EX_UND};
  logic [7:0] vt[15] = '{8'h04, 8'h0a, 8'h0a, 8'h0a, 8'h0a, 8'h0a, 8'h0a, 8'h0a, 8'h05,
    8'h06, 8'h07, 8'h08, 8'h0d, 8'h00, 8'h0a};
  assign {interruptible_point, debug_request_input_n, debug_condition_hit, bus_fault_input,
    page_fault_detect, insn_complete, boundary} = evb ^ 7'h20;
  always #2.5 clk_sys = ~clk_sys;
  cxu_exception_unit cxu_exception_unit_i (.*);
  cxu_bus_model cxu_bus_model_i (.*);
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic end_sim;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // One event cycle, then a bounded wait for every noted exception to appear.
  task automatic run(input cxu_decode_t d, input logic [6:0] ev, input cxu_exc_t k,
                     input logic [7:0] v, input logic r);
    int n;
    @(negedge clk_sys);
    lfsr = lfsr_next(lfsr);
    insn_addr = lfsr;
    decode = d;
    evb = ev;
    if (k != CXU_EX_NONE) q.push_back({k, v, r, lfsr});
    @(negedge clk_sys);
    decode = '0;
    evb = 7'h00;
    for (n = 0; n < 40 && q.size() > 0; n++) @(negedge clk_sys);
    if (q.size() > 0) begin
      $display("Error %0t: exception missing", $time);
      num_errors++;
      q.delete();
    end
    repeat (16) @(negedge clk_sys);
  endtask
  always @(posedge clk_sys) begin
    #1;
    if (action.take === 1'b1) begin
      comparisons++;
      if (q.size() == 0) begin
        $display("Error %0t: unexpected exception %0d", $time, action.kind);
        num_errors++;
      end else begin
        e = q.pop_front();
        if (action.kind !== e.k || action.vector !== e.v || (e.r && return_addr !== e.a)) begin
          $display("Error %0t: exception %0d vector %0h", $time, action.kind, action.vector);
          num_errors++;
        end
      end
    end
  end
  initial begin
    #100us;
    $display("Error %0t: watchdog expired", $time);
    num_errors++;
    end_sim();
  end
  initial begin
    cxu_decode_t d;
    cxu_decode_t dv;
    dv = '0;
    dv.valid = 1'b1;
    repeat (16) @(negedge clk_sys);
    rst_n = 1'b1;
    for (int i = 0; i < 15; i++) begin
      d = dv;
      user_mode = (i != 14);
      overflow_enable = (i == 12);
      status_flag = 1'b1;
      case (i)
        0: d.privileged = 1'b1;
        1: d.undefined_opcode = 1'b1;
        2: d.is_fpu = 1'b1;
        3: d.is_custom = 1'b1;
        4: d.is_mmu = 1'b1;
        5: d.mode_a = `CXU_MODE_RSVD;
        6: d.imm_on_nonread = 1'b1;
        7: d.scaled_over_scaled = 1'b1;
        8: d.is_svc = 1'b1;
        9: d.div_by_zero = 1'b1;
        10: d.is_flag_check = 1'b1;
        11: d.is_bpt = 1'b1;
        14: d.is_mmu_reg_xfer = 1'b1;
        default: d.overflow = 1'b1;
      endcase
      run(d, (i == 12 || i == 13) ? 7'h02 : 7'h00, kt[i], vt[i], i < 12 || i == 14);
    end
    {user_mode, overflow_enable, status_flag, slow, nmi_request_n} = 5'h02;
    run('0, 7'h01, CXU_EX_NMI, 8'h01, 1'b0);
    run('0, 7'h01, CXU_EX_NONE, 8'h00, 1'b0);
    {nmi_request_n, int_enable, maskable_request_n} = 3'h6;
    run('0, 7'h01, CXU_EX_INT, 8'h00, 1'b0);
    run('0, 7'h40, CXU_EX_INT, 8'h00, 1'b0);
    nmi_request_n = 1'b0;
    run('0, 7'h01, CXU_EX_NMI, 8'h01, 1'b0);
    run('0, 7'h01, CXU_EX_INT, 8'h00, 1'b0);
    {nmi_request_n, int_enable} = 2'h2;
    run('0, 7'h01, CXU_EX_NONE, 8'h00, 1'b0);
    maskable_request_n = 1'b1;
    run('0, 7'h21, CXU_EX_DBG, 8'h0e, 1'b0);
    nmi_request_n = 1'b0;
    run('0, 7'h11, CXU_EX_DBG, 8'h0e, 1'b0);
    run('0, 7'h01, CXU_EX_NMI, 8'h01, 1'b0);
    {nmi_request_n, step_pending} = 2'h3;
    run('0, 7'h01, CXU_EX_STP, 8'h09, 1'b0);
    {step_pending, overflow_enable} = 2'h1;
    d = dv;
    d.overflow = 1'b1;
    run(d, 7'h12, CXU_EX_OVF, 8'h0d, 1'b0);
    run('0, 7'h01, CXU_EX_DBG, 8'h0e, 1'b0);
    overflow_enable = 1'b0;
    d = dv;
    d.is_svc = 1'b1;
    run(d, 7'h10, CXU_EX_SVC, 8'h05, 1'b1);
    run('0, 7'h03, CXU_EX_NONE, 8'h00, 1'b0);
    run(dv, 7'h04, CXU_EX_ABT, 8'h02, 1'b1);
    bus_cycle = 7'h64;
    run(dv, 7'h08, CXU_EX_RBE, 8'h0b, 1'b1);
    run(dv, 7'h0c, CXU_EX_ABT, 8'h02, 1'b1);
    bus_cycle = 7'h60;
    run(dv, 7'h08, CXU_EX_NONE, 8'h00, 1'b0);
    bus_cycle = 7'h48;
    run(dv, 7'h08, CXU_EX_NBE, 8'h0c, 1'b0);
    bus_cycle = 7'h74;
    run(dv, 7'h08, CXU_EX_NBE, 8'h0c, 1'b0);
    bus_cycle = 7'h44;
    run(dv, 7'h08, CXU_EX_NBE, 8'h0c, 1'b0);
    for (int j = 0; j < 2; j++) begin
      bus_cycle = (j == 0) ? 7'h46 : 7'h65;
      run(dv, 7'h08, CXU_EX_NONE, 8'h00, 1'b0);
      comparisons++;
      if (stopped_state !== 1'b1) begin
        $display("Error %0t: unit not stopped", $time);
        num_errors++;
      end
      rst_n = 1'b0;
      bus_cycle = '0;
      @(negedge clk_sys);
      rst_n = 1'b1;
    end
    end_sim();
  end
endmodule

// ==== verilog/cxu_edge_detect.sv ====
/*
  Falling-edge detector with a sticky request flag; the set wins over the
  clear in the same cycle.
  Assumes the input is synchronous to clk_sys.
*/
`timescale 1ns/100ps
module cxu_edge_detect (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic level_n,
  input wire logic clear,
  output logic pending
);
  logic last;
  logic fall;

  assign fall = last & ~level_n;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      last <= 1'b1;
    end else begin
      last <= level_n;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pending <= 1'b0;
    end else if (fall) begin
      pending <= 1'b1;
    end else if (clear) begin
      pending <= 1'b0;
    end
  end
endmodule

// ==== verilog/cxu_exception_unit.sv ====
/*
  Exception recognition and prioritisation for a 32-bit core: decodes trap
  conditions, sorts bus faults, picks the winning exception and drives the
  interrupt-acknowledge request.
  Assumes the pipeline presents one instruction's decode flags per cycle,
  signals boundary and completion, and handles the service sequence itself.
*/
`timescale 1ns/100ps
`include "cxu_regs.svh"
module cxu_exception_unit
  import cxu_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic nmi_request_n,
  input wire logic maskable_request_n,
  input wire logic debug_request_input_n,
  input wire logic bus_fault_input,
  input wire cxu_cycle_t bus_cycle,
  input wire logic [2:0] setup_word,
  input wire logic user_mode,
  input wire logic int_enable,
  input wire logic overflow_enable,
  input wire logic status_flag,
  input wire logic step_pending,
  input wire logic debug_condition_hit,
  input wire logic page_fault_detect,
  input wire cxu_decode_t decode,
  input wire logic boundary,
  input wire logic interruptible_point,
  input wire logic insn_complete,
  input wire logic [31:0] insn_addr,
  input wire logic ack_done,
  input wire logic service_done,
  output cxu_action_t action,
  output logic [31:0] return_addr,
  output logic ack_req,
  output logic [31:0] ack_addr,
  output logic [4:0] ack_status,
  output logic data_ref_block,
  output logic mem_ref_stall,
  output logic debug_status_update,
  output logic stopped_state
);
  typedef enum logic [1:0] {S_RUN, S_ACK, S_SERVICE, S_STOP} cxu_state_t;

  cxu_state_t state;
  logic nmi_pending;
  logic nmi_clear;
  logic debug_pending;
  logic rbe_pending;
  logic in_service;
  logic ack_is_nmi;
  logic mode_bad;
  logic und_trap;
  logic prv_trap;
  logic insn_trap;
  logic fault_seen;
  logic fault_restartable;
  logic fault_fatal;
  logic fault_nonrestart;
  logic nonrestart_pend;
  logic int_ok;
  logic dbg_now;

  logic und_opcode;
  logic und_unit_off;
  logic und_encoding;
  logic und_mmu_xfer;
  logic slv_trap;
  logic svc_trap;
  logic dvz_trap;
  logic bpt_trap;
  logic flg_trap;
  logic ovf_trap;

  logic check_point;
  logic run_take;
  logic debug_hold;

  cxu_action_t next_action;

  // The edge is latched so that a request seen during service waits its turn.
  cxu_edge_detect u_nmi_edge (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .level_n(nmi_request_n),
    .clear(nmi_clear),
    .pending(nmi_pending)
  );

  // Unknown opcode conditions, one signal for each family of causes.
  assign mode_bad = (decode.mode_a == `CXU_MODE_RSVD) ||
                    (decode.mode_b == `CXU_MODE_RSVD);
  assign und_opcode = decode.valid & decode.undefined_opcode;
  // A coprocessor or memory-management opcode is legal only while its unit is set up.
  assign und_unit_off = decode.valid &
      ((decode.is_fpu & ~setup_word[`CXU_SETUP_FPU]) |
       (decode.is_custom & ~setup_word[`CXU_SETUP_CUS]) |
       (decode.is_mmu & ~setup_word[`CXU_SETUP_MMU]));
  assign und_encoding = decode.valid &
      (mode_bad | decode.imm_on_nonread | decode.scaled_over_scaled);
  // In supervisor mode a register transfer with a clear short-field top bit is undefined.
  assign und_mmu_xfer = decode.valid & decode.is_mmu_reg_xfer & ~user_mode &
      ~decode.short_msb;
  assign und_trap = und_opcode | und_unit_off | und_encoding | und_mmu_xfer;
  // An unknown opcode masks the privilege check, so only one of the two is named.
  assign prv_trap = decode.valid & ~und_trap & decode.privileged & user_mode;
  assign slv_trap = decode.valid & decode.slave_trap;
  assign svc_trap = decode.valid & decode.is_svc;
  assign dvz_trap = decode.valid & decode.div_by_zero;
  assign bpt_trap = decode.valid & decode.is_bpt;
  assign flg_trap = decode.valid & decode.is_flag_check & status_flag;
  assign insn_trap = und_trap | prv_trap | slv_trap | svc_trap | dvz_trap | bpt_trap |
      flg_trap;
  // Operand fetch is held back as soon as the opcode is known to be bad.
  assign data_ref_block = und_trap | prv_trap;

  // Bus fault sorting. Faults on cycles of instructions that never run are ignored,
  // except the referenced-bit update, which cannot be undone.
  assign fault_seen = bus_fault_input & bus_cycle.active &
      (bus_cycle.executed | bus_cycle.mmu_ref_bit_write);
  assign fault_fatal = fault_seen &
      (bus_cycle.for_exception | bus_cycle.icu_read_for_iret);
  assign fault_restartable = fault_seen & ~fault_fatal & bus_cycle.is_read &
      ~bus_cycle.mmu_table_read_for_store & ~bus_cycle.mmu_ref_bit_write;
  assign fault_nonrestart = fault_seen & ~fault_fatal & ~fault_restartable;
  assign nonrestart_pend = fault_nonrestart;

  // A held low level keeps requesting, so another acknowledge may follow each return.
  assign int_ok = ~maskable_request_n & int_enable;
  // A debug condition met in the checking cycle itself counts as pending.
  assign dbg_now = debug_pending | debug_condition_hit | ~debug_request_input_n;
  assign ovf_trap = insn_complete & decode.overflow & overflow_enable;
  assign check_point = boundary | interruptible_point;
  assign run_take = (state == S_RUN) & next_action.take & ~fault_fatal;
  assign debug_hold = (next_action.kind == CXU_EX_OVF);
  assign mem_ref_stall = rbe_pending;
  assign stopped_state = (state == S_STOP);
  assign in_service = (state != S_RUN);

  always_comb begin
    next_action = '0;
    next_action.kind = CXU_EX_NONE;
    // A non-restartable fault is taken at once, whatever the pipeline is doing.
    if (nonrestart_pend) begin
      next_action.take = 1'b1;
      next_action.kind = CXU_EX_NBE;
      next_action.vector = `CXU_VEC_NBE;
      next_action.ret_undefined = 1'b1;
      next_action.clear_int_enable = 1'b1;
    end else if (page_fault_detect | fault_restartable) begin
      // Whichever arrives first is seen first; same cycle favours page fault.
      next_action.take = 1'b1;
      next_action.kind = page_fault_detect ? CXU_EX_ABT : CXU_EX_RBE;
      next_action.vector = page_fault_detect ? `CXU_VEC_ABT : `CXU_VEC_RBE;
      next_action.ret_first_byte = 1'b1;
      next_action.clear_int_enable = 1'b1;
    end else if (insn_trap) begin
      // The in-instruction traps exclude each other; the order only settles bad decode.
      next_action.take = 1'b1;
      next_action.ret_first_byte = 1'b1;
      next_action.clear_int_enable = 1'b0;
      if (und_trap) begin
        next_action.kind = CXU_EX_UND;
        next_action.vector = `CXU_VEC_UND;
      end else if (prv_trap) begin
        next_action.kind = CXU_EX_PRV;
        next_action.vector = `CXU_VEC_PRV;
      end else if (decode.slave_trap) begin
        next_action.kind = CXU_EX_SLV;
        next_action.vector = `CXU_VEC_SLV;
      end else if (decode.is_svc) begin
        next_action.kind = CXU_EX_SVC;
        next_action.vector = `CXU_VEC_SVC;
      end else if (decode.div_by_zero) begin
        next_action.kind = CXU_EX_DVZ;
        next_action.vector = `CXU_VEC_DVZ;
      end else if (decode.is_bpt) begin
        next_action.kind = CXU_EX_BPT;
        next_action.vector = `CXU_VEC_BPT;
      end else begin
        next_action.kind = CXU_EX_FLG;
        next_action.vector = `CXU_VEC_FLG;
      end
    end else if (ovf_trap) begin
      // Overflow is only known once the result is written and the counter has moved on.
      next_action.take = 1'b1;
      next_action.kind = CXU_EX_OVF;
      next_action.vector = `CXU_VEC_OVF;
    end else if (check_point) begin
      // Checks between instructions or at an interruptible step of a long one.
      if (dbg_now) begin
        next_action.take = 1'b1;
        next_action.kind = CXU_EX_DBG;
        next_action.vector = `CXU_VEC_DBG;
        next_action.clear_int_enable = 1'b1;
      end else if (nmi_pending) begin
        next_action.take = 1'b1;
        next_action.kind = CXU_EX_NMI;
        next_action.vector = `CXU_VEC_NMI;
        next_action.clear_int_enable = 1'b1;
      end else if (int_ok) begin
        next_action.take = 1'b1;
        next_action.kind = CXU_EX_INT;
        next_action.vector = `CXU_VEC_NVI;
        next_action.clear_int_enable = 1'b1;
      end else if (step_pending & boundary) begin
        next_action.take = 1'b1;
        next_action.kind = CXU_EX_STP;
        next_action.vector = `CXU_VEC_STP;
      end
    end
  end

  assign nmi_clear = (state == S_RUN) & ~fault_fatal & (next_action.kind == CXU_EX_NMI);

  // A fault while an exception is under way cannot be recovered, so it stops the unit
  // from any state until the next reset.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_RUN;
    end else begin
      unique case (state)
        S_RUN: begin
          if (fault_fatal) begin
            state <= S_STOP;
          end else if (next_action.take) begin
            state <= (next_action.kind == CXU_EX_NMI ||
                      next_action.kind == CXU_EX_INT) ? S_ACK : S_SERVICE;
          end
        end
        S_ACK: begin
          if (fault_fatal) begin
            state <= S_STOP;
          end else if (ack_done) begin
            state <= S_SERVICE;
          end
        end
        S_SERVICE: begin
          if (fault_fatal) begin
            state <= S_STOP;
          end else if (service_done) begin
            state <= S_RUN;
          end
        end
        S_STOP: begin
          // Only reset leaves the stopped state.
          state <= S_STOP;
        end
      endcase
    end
  end

  // Action fields stay after the pulse so the pipeline can read them while it services.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      action <= '0;
      return_addr <= 32'h0000_0000;
      ack_is_nmi <= 1'b0;
    end else if (state == S_RUN && next_action.take && !fault_fatal) begin
      action <= next_action;
      // A terminated instruction leaves no meaningful return address.
      return_addr <= next_action.ret_undefined ? 32'h0000_0000 : insn_addr;
      ack_is_nmi <= (next_action.kind == CXU_EX_NMI);
    end else begin
      action.take <= 1'b0;
    end
  end

  // Debug condition held until completion, dropped on any other exception. An overflow
  // trap goes first and leaves it pending; a condition met with the taking of another
  // exception is dropped with it.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      debug_pending <= 1'b0;
    end else if (run_take && !debug_hold) begin
      debug_pending <= 1'b0;
    end else if (debug_condition_hit & ~in_service) begin
      debug_pending <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      debug_status_update <= 1'b0;
    end else begin
      // Only a debug trap that is actually taken may touch the debug status word.
      debug_status_update <= run_take & (next_action.kind == CXU_EX_DBG);
    end
  end

  // Later instructions make no memory references until the faulting one is known to
  // execute and its exception has been serviced.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rbe_pending <= 1'b0;
    end else if (fault_restartable & ~in_service) begin
      rbe_pending <= 1'b1;
    end else if (state == S_SERVICE && service_done) begin
      rbe_pending <= 1'b0;
    end
  end

  // Registered so that the bus sees settled request, address and status together.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ack_req <= 1'b0;
      ack_addr <= 32'h0000_0000;
      ack_status <= 5'h00;
    end else begin
      ack_req <= (state == S_ACK) & ~ack_done;
      ack_addr <= ack_is_nmi ? `CXU_NMI_ACK_ADDR : `CXU_INT_ACK_ADDR;
      ack_status <= `CXU_ACK_STATUS;
    end
  end
endmodule

// ==== verilog/cxu_pkg.sv ====
/*
  Types of the exception priority unit.
  Assumes cxu_regs.svh is on the include path.
*/
package cxu_pkg;
  typedef enum logic [3:0] {
    CXU_EX_NONE, CXU_EX_NBE, CXU_EX_RBE, CXU_EX_ABT, CXU_EX_DBG, CXU_EX_NMI,
    CXU_EX_INT, CXU_EX_STP, CXU_EX_PRV, CXU_EX_UND, CXU_EX_SVC, CXU_EX_DVZ,
    CXU_EX_FLG, CXU_EX_BPT, CXU_EX_OVF, CXU_EX_SLV
  } cxu_exc_t;

  typedef struct packed {
    logic valid;
    logic undefined_opcode;
    logic is_fpu;
    logic is_custom;
    logic is_mmu;
    logic is_mmu_reg_xfer;
    logic short_msb;
    logic privileged;
    logic [4:0] mode_a;
    logic [4:0] mode_b;
    logic imm_on_nonread;
    logic scaled_over_scaled;
    logic is_svc;
    logic is_bpt;
    logic is_flag_check;
    logic div_by_zero;
    logic overflow;
    logic slave_trap;
  } cxu_decode_t;

  typedef struct packed {
    logic active;
    logic is_read;
    logic mmu_table_read_for_store;
    logic mmu_ref_bit_write;
    logic executed;
    logic for_exception;
    logic icu_read_for_iret;
  } cxu_cycle_t;

  typedef struct packed {
    logic take;
    cxu_exc_t kind;
    logic [7:0] vector;
    logic ret_first_byte;
    logic ret_undefined;
    logic clear_int_enable;
  } cxu_action_t;
endpackage

// ==== verilog/cxu_regs.svh ====
/*
  Constants of the exception priority unit: vectors, acknowledge addresses,
  setup-word bit positions and addressing-mode codes.
  Assumes inclusion by bare name from the exception unit and the bench.
*/
`ifndef CXU_REGS_SVH
`define CXU_REGS_SVH
`define CXU_NMI_ACK_ADDR 32'h0ffff_f00
`define CXU_INT_ACK_ADDR 32'h0ffff_e00
`define CXU_VEC_NVI 8'h00
`define CXU_VEC_NMI 8'h01
`define CXU_VEC_ABT 8'h02
`define CXU_VEC_SLV 8'h03
`define CXU_VEC_PRV 8'h04
`define CXU_VEC_SVC 8'h05
`define CXU_VEC_DVZ 8'h06
`define CXU_VEC_FLG 8'h07
`define CXU_VEC_BPT 8'h08
`define CXU_VEC_STP 8'h09
`define CXU_VEC_UND 8'h0a
`define CXU_VEC_RBE 8'h0b
`define CXU_VEC_NBE 8'h0c
`define CXU_VEC_OVF 8'h0d
`define CXU_VEC_DBG 8'h0e
`define CXU_SETUP_FPU 0
`define CXU_SETUP_MMU 1
`define CXU_SETUP_CUS 2
`define CXU_MODE_RSVD 5'h13
`define CXU_ACK_STATUS 5'h04
`endif
